// [logic/cca_cfg.svh]
// Summary of operation
// - either capture enable selects capture mode
// - sample pin for selected edge directions
// - capture copies counter into compare bytes
// - capture flag with enable requests interrupt
// - comparator plus match enable, toggle and pwm clear, gives timer
// - compare equality sets flag, may interrupt
// - fast output toggles pin on every match
// - fast output needs toggle, match, comparator
// - pwm needs comparator, pwm, others clear
// - pwm low below duty, high otherwise
// - low byte wrap reloads duty from high
// - one shared counter times all modules
// - only module four can be watchdog
// - watchdog needs compare mode plus arm
// - armed match raises internal reset only
// - arm bit clear suppresses, set re-arms
`ifndef CCA_CFG_SVH
`define CCA_CFG_SVH

// =============================================================
// structure
`define CCA_UNITS          5
`define CCA_WD_UNIT        4

// =============================================================
// register byte addresses
`define CCA_ADDR_CTRL      8'h00
`define CCA_ADDR_CMODE     8'h01
`define CCA_ADDR_CNT_LO    8'h02
`define CCA_ADDR_CNT_HI    8'h03
`define CCA_ADDR_MODE_BASE 8'h10
`define CCA_ADDR_CMPL_BASE 8'h20
`define CCA_ADDR_CMPH_BASE 8'h28

// =============================================================
// field positions
`define CCA_RUN_BIT        6
`define CCA_WDARM_BIT      6

// =============================================================
// reset values
`define CCA_MODE_RST       7'h00
`define CCA_BYTE_RST       8'h00
`define CCA_CNT_RST        16'h0000
`define CCA_FLAGS_RST      5'h00

`endif

// [logic/cca_pkg.sv]
package cca_pkg;

   // =============================================================
   // per-module mode register fields, bit 6 down to bit 0
   typedef struct packed {
      logic ecom;   // comparator_enable
      logic capp;   // rise_capture_enable
      logic capn;   // fall_capture_enable
      logic mat;    // match_flag_enable
      logic tog;    // match_toggle_enable
      logic pwm;    // pulse_width_select
      logic eccf;   // module_irq_enable
   } cca_mode_t;

   // =============================================================
   // module function selected by the mode bits
   typedef enum logic [2:0] {
      CCA_IDLE,
      CCA_CAPTURE,
      CCA_TIMER,
      CCA_HSO,
      CCA_PWM
   } cca_func_t;

   // =============================================================
   // register bus request bundle
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } cca_bus_t;

   // decode mode bits into one function
   function automatic cca_func_t cca_decode(input cca_mode_t m);
      cca_func_t f;
      f = CCA_IDLE;
      if (m.capp || m.capn)
         f = CCA_CAPTURE;
      else if (m.ecom && m.pwm && !m.mat && !m.tog && !m.eccf)
         f = CCA_PWM;
      else if (m.ecom && m.mat && m.tog && !m.pwm)
         f = CCA_HSO;
      else if (m.ecom && m.mat && !m.pwm)
         f = CCA_TIMER;
      return f;
   endfunction

   // true when addr falls in a five-entry per-module block
   function automatic logic cca_in_block(input logic [7:0] addr, input logic [7:0] base);
      logic [7:0] off;
      off = addr - base;
      return (addr >= base) && (off < 8'h05);
   endfunction

   // index of a module inside its address block
   function automatic logic [2:0] cca_index(input logic [7:0] addr, input logic [7:0] base);
      logic [7:0] off;
      off = addr - base;
      return off[2:0];
   endfunction

endpackage

// [logic/cca_sync.sv]
// =============================================================
// two-stage synchroniser for asynchronous pin levels
module cca_sync #(
   parameter int W = 5
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_q;   // first stage, read only by second stage

   // two flops, frozen while clock enable is low
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= '0;
         q      <= '0;
      end
      else if (ce)
      begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule

// [logic/cca_unit.sv]
`include "cca_cfg.svh"

// =============================================================
// one compare/capture module: decode, match, edge and pin output
module cca_unit
   import cca_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      rst_n,
   input  wire logic      ce,
   input  wire cca_mode_t mode,
   input  wire logic [15:0] counter,
   input  wire logic [15:0] cmp,
   input  wire logic      pin_sync,
   output cca_func_t      func,
   output logic           match_evt,
   output logic           cap_evt,
   output logic           pin_q
);

   logic match_prev_q;   // match seen last cycle
   logic pin_prev_q;     // synced pin last cycle
   logic match_now;      // counter equals compare this cycle
   logic rise;           // rising transition on pin
   logic fall;           // falling transition on pin
   logic pwm_level;      // pwm output level
   logic pin_d;          // next output pin value

   assign func      = cca_decode(mode);
   assign match_now = ((func == CCA_TIMER) || (func == CCA_HSO)) && (counter == cmp);
   assign match_evt = match_now && !match_prev_q;                                  // one event per equality
   assign rise      = pin_sync && !pin_prev_q;
   assign fall      = !pin_sync && pin_prev_q;
   assign cap_evt   = (func == CCA_CAPTURE) && ((mode.capp && rise) || (mode.capn && fall));
   assign pwm_level = counter[7:0] >= cmp[7:0];
   assign pin_d     = (func == CCA_PWM) ? pwm_level :
                      ((func == CCA_HSO) && match_evt) ? !pin_q : pin_q;

   // history flops and the output pin register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         match_prev_q <= 1'b0;
         pin_prev_q   <= 1'b0;
         pin_q        <= 1'b0;
      end
      else if (ce)
      begin
         match_prev_q <= match_now;
         pin_prev_q   <= pin_sync;
         pin_q        <= pin_d;
      end
   end

endmodule

// [logic/cca_top.sv]
`include "cca_cfg.svh"

// =============================================================
// counter array: shared counter, five compare/capture modules
// one shared 16-bit time base
// five identical module slices
// one register port, no wait
// pins cross in through two flops
// each slice picks its function
// from its own mode byte
// module four may also watch
// the software, via the arm bit
// all outputs leave from flops
module cca_top
   import cca_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   input  wire logic [7:0] bus_addr,
   input  wire logic [7:0] bus_wdata,
   input  wire logic       bus_wr,
   input  wire logic       bus_rd,
   output logic      [7:0] bus_rdata_q,
   input  wire logic [4:0] module_pin_in,
   output logic      [4:0] module_pin_out,
   output logic      [4:0] module_pin_oe_q,
   output logic            irq_q,
   output logic            wd_reset_q
);

   // =============================================================
   // reset release synchroniser
   // rst_n drops at once,
   // but rises through two flops
   // so no flop leaves reset
   // on a different edge;
   // clock enable is ignored here
   // so the design can always
   // leave reset, even frozen
   // srst_n feeds every process
   // below this point
   logic       rst_meta_q;     // first reset stage
   logic       rst_sync_q;     // released reset for the design
   logic       srst_n;         // internal active-low reset

   // plain two-flop release, not gated by clock enable
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   assign srst_n = rst_sync_q;

   // =============================================================
   // bus bundle and address decode
   // a strobe lasts one cycle;
   // decode is pure wiring
   // so a write lands at the
   // very edge that samples it
   // and the slave never stalls
   // per-module blocks decode
   // by range, then by index
   // unmapped writes fall through
   // and change nothing
   cca_bus_t   bus;            // bundled request
   logic       wr_ctrl;        // counter_control_register write
   logic       wr_cmode;       // counter_mode_register write
   logic       wr_cnt_lo;      // counter_low write
   logic       wr_cnt_hi;      // counter_high write
   logic       hit_mode;       // mode register block hit
   logic       hit_cmpl;       // compare_low block hit
   logic       hit_cmph;       // compare_high block hit
   logic [2:0] idx_mode;       // module index in mode block
   logic [2:0] idx_cmpl;       // module index in compare_low block
   logic [2:0] idx_cmph;       // module index in compare_high block

   assign bus       = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};
   assign wr_ctrl   = bus.wr && (bus.addr == `CCA_ADDR_CTRL);
   assign wr_cmode  = bus.wr && (bus.addr == `CCA_ADDR_CMODE);
   assign wr_cnt_lo = bus.wr && (bus.addr == `CCA_ADDR_CNT_LO);
   assign wr_cnt_hi = bus.wr && (bus.addr == `CCA_ADDR_CNT_HI);
   assign hit_mode  = cca_in_block(bus.addr, `CCA_ADDR_MODE_BASE);
   assign hit_cmpl  = cca_in_block(bus.addr, `CCA_ADDR_CMPL_BASE);
   assign hit_cmph  = cca_in_block(bus.addr, `CCA_ADDR_CMPH_BASE);
   assign idx_mode  = cca_index(bus.addr, `CCA_ADDR_MODE_BASE);
   assign idx_cmpl  = cca_index(bus.addr, `CCA_ADDR_CMPL_BASE);
   assign idx_cmph  = cca_index(bus.addr, `CCA_ADDR_CMPH_BASE);

   // =============================================================
   // control bits, shared counter
   // run starts and stops counting
   // arm enables the watchdog
   // counter bytes may be written
   // while running; a byte write
   // wins over the increment
   // of that edge, so software
   // sees what it wrote
   // lo_wrap marks the FF to 00
   // step that reloads pwm duty
   logic        run_q;         // counter run control
   logic        wd_arm_q;      // watchdog_arm
   logic [15:0] cnt_q;         // shared counter, high:low
   logic [15:0] cnt_d;         // next counter value
   logic        lo_wrap;       // low byte steps from FF to 00

   assign lo_wrap = run_q && (cnt_q[7:0] == 8'hFF);

   // counter next value: software byte writes win over counting
   always_comb
   begin
      cnt_d = cnt_q;
      if (run_q)
         cnt_d = cnt_q + 16'h0001;
      if (wr_cnt_lo)
         cnt_d[7:0] = bus.wdata;
      if (wr_cnt_hi)
         cnt_d[15:8] = bus.wdata;
   end

   // run, arm and counter registers
   always_ff @(posedge clk or negedge srst_n)
   begin
      if (!srst_n)
      begin
         run_q    <= 1'b0;
         wd_arm_q <= 1'b0;
         cnt_q    <= `CCA_CNT_RST;
      end
      else if (ce)
      begin
         if (wr_ctrl)
            run_q <= bus.wdata[`CCA_RUN_BIT];
         if (wr_cmode)
            wd_arm_q <= bus.wdata[`CCA_WDARM_BIT];
         cnt_q <= cnt_d;
      end
   end

   // =============================================================
   // per-module registers and logic
   // slice i owns mode, compare
   // low and compare high bytes
   // compare low doubles as the
   // active duty byte, compare
   // high as the reload byte
   // a capture beats a software
   // write in the same cycle
   // so a measured edge is
   // never lost
   cca_mode_t   mode_q  [`CCA_UNITS];    // module_mode_control
   logic [7:0]  cmpl_q  [`CCA_UNITS];    // compare_low / active_duty_byte
   logic [7:0]  cmph_q  [`CCA_UNITS];    // compare_high / reload_duty_byte
   cca_func_t   func    [`CCA_UNITS];    // decoded function
   logic [4:0]  match_evt;               // compare match events
   logic [4:0]  cap_evt;                 // capture events
   logic [4:0]  pin_sync;                // synchronised pins
   logic [4:0]  flags_q;                 // module_event_flag bits
   logic [4:0]  flags_d;                 // next flags
   logic [4:0]  irq_en;                  // module_irq_enable bits
   logic [4:0]  drive_en;                // module drives its pin

   // pins pass two flops before any logic sees them
   cca_sync #(
      .W (5)
   ) u_sync (
      .clk   (clk),
      .rst_n (srst_n),
      .ce    (ce),
      .d     (module_pin_in),
      .q     (pin_sync)
   );

   for (genvar i = 0; i < `CCA_UNITS; i++)
   begin : g_unit
      logic cap_here;     // capture into this module
      logic reload_here;  // pwm duty reload for this module

      assign cap_here    = cap_evt[i];
      assign reload_here = (func[i] == CCA_PWM) && lo_wrap;
      assign irq_en[i]   = mode_q[i].eccf;
      assign drive_en[i] = (func[i] == CCA_HSO) || (func[i] == CCA_PWM);

      cca_unit u_unit (
         .clk       (clk),
         .rst_n     (srst_n),
         .ce        (ce),
         .mode      (mode_q[i]),
         .counter   (cnt_q),
         .cmp       ({cmph_q[i], cmpl_q[i]}),
         .pin_sync  (pin_sync[i]),
         .func      (func[i]),
         .match_evt (match_evt[i]),
         .cap_evt   (cap_evt[i]),
         .pin_q     (module_pin_out[i])
      );

      // mode register; reserved bit 7 is not stored
      always_ff @(posedge clk or negedge srst_n)
      begin
         if (!srst_n)
            mode_q[i] <= `CCA_MODE_RST;
         else if (ce && bus.wr && hit_mode && (idx_mode == 3'(i)))
            mode_q[i] <= bus.wdata[6:0];
      end

      // compare bytes: capture beats software write beats reload
      always_ff @(posedge clk or negedge srst_n)
      begin
         if (!srst_n)
         begin
            cmpl_q[i] <= `CCA_BYTE_RST;
            cmph_q[i] <= `CCA_BYTE_RST;
         end
         else if (ce)
         begin
            if (cap_here)
            begin
               cmpl_q[i] <= cnt_q[7:0];
               cmph_q[i] <= cnt_q[15:8];
            end
            else
            begin
               if (bus.wr && hit_cmpl && (idx_cmpl == 3'(i)))
                  cmpl_q[i] <= bus.wdata;
               else if (reload_here)
                  cmpl_q[i] <= cmph_q[i];
               if (bus.wr && hit_cmph && (idx_cmph == 3'(i)))
                  cmph_q[i] <= bus.wdata;
            end
         end
      end
   end

   // =============================================================
   // event flags, interrupt, pin enables
   // flags stay set until
   // software clears them
   // a write of one sets a flag
   // an event in the cycle of
   // a clearing write wins
   // irq_q follows the next
   // flag value at once
   // pin enables follow the
   // decoded mode one edge late
   // flags: software writes set or clear, hardware events win
   assign flags_d = (wr_ctrl ? bus.wdata[4:0] : flags_q) | match_evt | cap_evt;

   always_ff @(posedge clk or negedge srst_n)
   begin
      if (!srst_n)
      begin
         flags_q         <= `CCA_FLAGS_RST;
         irq_q           <= 1'b0;
         module_pin_oe_q <= 5'h00;
      end
      else if (ce)
      begin
         flags_q         <= flags_d;
         irq_q           <= |(flags_d & irq_en);
         module_pin_oe_q <= drive_en;
      end
   end

   // =============================================================
   // watchdog on module four
   // a match on module four
   // with arm set raises a
   // one-cycle reset request
   // for the rest of the chip;
   // the block itself keeps
   // running, and the external
   // reset pin is untouched
   // clearing arm before a
   // match holds it off
   logic wd_fire;   // armed compare match on the watchdog module

   // only module four, compare mode, arm set
   assign wd_fire = wd_arm_q && match_evt[`CCA_WD_UNIT] &&
                    ((func[`CCA_WD_UNIT] == CCA_TIMER) || (func[`CCA_WD_UNIT] == CCA_HSO));

   // one-cycle internal reset pulse, no external pin involved
   always_ff @(posedge clk or negedge srst_n)
   begin
      if (!srst_n)
         wd_reset_q <= 1'b0;
      else if (ce)
         wd_reset_q <= wd_fire;
   end

   // =============================================================
   // read path
   // read data stand for one
   // cycle after the strobe,
   // zero otherwise, so a bus
   // with several slaves can
   // simply or them together
   // reserved bits read zero
   // unmapped addresses too
   // counter bytes are read
   // live, with no latching
   logic [7:0] rd_mux;   // selected read value

   // address decode for reads, unmapped reads zero
   always_comb
   begin
      rd_mux = 8'h00;
      if (bus.addr == `CCA_ADDR_CTRL)
         rd_mux = {1'b0, run_q, 1'b0, flags_q};
      else if (bus.addr == `CCA_ADDR_CMODE)
         rd_mux = {1'b0, wd_arm_q, 6'h00};
      else if (bus.addr == `CCA_ADDR_CNT_LO)
         rd_mux = cnt_q[7:0];
      else if (bus.addr == `CCA_ADDR_CNT_HI)
         rd_mux = cnt_q[15:8];
      else if (hit_mode)
         rd_mux = {1'b0, mode_q[idx_mode]};
      else if (hit_cmpl)
         rd_mux = cmpl_q[idx_cmpl];
      else if (hit_cmph)
         rd_mux = cmph_q[idx_cmph];
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge clk or negedge srst_n)
   begin
      if (!srst_n)
         bus_rdata_q <= 8'h00;
      else if (ce)
         bus_rdata_q <= bus.rd ? rd_mux : 8'h00;
   end

endmodule

// [verification/cca_pin_model.sv]
// ====
// far side of the module pins
module cca_pin_model (
   input  wire logic [4:0] level,
   input  wire logic [4:0] pin_out,
   input  wire logic [4:0] pin_oe_q,
   output logic      [4:0] pin_wire
);
   timeunit 1ns;
   timeprecision 1ps;
   // driven pins carry the block's level, the rest the far side's edges
   assign pin_wire = (pin_oe_q & pin_out) | (~pin_oe_q & level);
endmodule

// [verification/cca_top_props.sv]
// ====
// port checker for the counter array
module cca_top_props (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       ce,
   input wire logic [7:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic       bus_wr,
   input wire logic       bus_rd,
   input wire logic [7:0] bus_rdata_q,
   input wire logic [4:0] module_pin_in,
   input wire logic [4:0] module_pin_out,
   input wire logic [4:0] module_pin_oe_q,
   input wire logic       irq_q,
   input wire logic       wd_reset_q
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [6:0] mode_q [5]; // mode register shadows
   logic       arm_q;      // watchdog_arm shadow
   logic [1:0] stab_q;     // cycles since a mode write
   logic [7:0] rb_q;       // expected read data
   logic       rb_v_q;     // read check due
   logic [4:0] oe_exp;
   logic [4:0] eccf;
   wire in_mode = (bus_addr >= 8'h10) && (bus_addr <= 8'h14);
   wire mode_wr = bus_wr && ce && in_mode;
   wire wd_mode = mode_q[4][6] && mode_q[4][3] && (mode_q[4][5:4] == 2'h0) && !mode_q[4][1];
   // pins are driven only in fast output and pwm modes
   for (genvar i = 0; i < 5; i++)
   begin : g_dec
      assign eccf[i]   = mode_q[i][0];
      assign oe_exp[i] = mode_q[i][6] && (mode_q[i][5:4] == 2'h0)
                         && ((mode_q[i][3:1] == 3'h6) || (mode_q[i][3:0] == 4'h2));
   end
   // ====
   // shadow registers fed from the bus
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_q <= '{default: 7'h00};
         arm_q  <= 1'b0;
         stab_q <= 2'h0;
         rb_q   <= 8'h00;
         rb_v_q <= 1'b0;
      end
      else
      begin
         if (mode_wr)
            mode_q[bus_addr[2:0]] <= bus_wdata[6:0];
         if (bus_wr && ce && (bus_addr == 8'h01))
            arm_q <= bus_wdata[6];
         stab_q <= mode_wr ? 2'h0 : ((stab_q == 2'h3) ? stab_q : stab_q + 2'h1);
         rb_v_q <= bus_rd && ce && (in_mode || (bus_addr == 8'hFF));
         rb_q   <= in_mode ? {1'b0, mode_q[bus_addr[2:0]]} : 8'h00;
      end
   end
   // ====
   // assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   property p_oe_mode;
      stab_q >= 2'h2 |-> module_pin_oe_q == oe_exp;
   endproperty
   a_oe_mode: assert property (p_oe_mode) else $error("pin enable wrong for mode");
   property p_wd_arm;
      wd_reset_q |-> $past(arm_q);
   endproperty
   a_wd_arm: assert property (p_wd_arm) else $error("watchdog reset while disarmed");
   property p_wd_unit;
      wd_reset_q |-> $past(wd_mode);
   endproperty
   a_wd_unit: assert property (p_wd_unit) else $error("watchdog reset outside compare mode");
   property p_wd_pulse;
      wd_reset_q |=> !wd_reset_q;
   endproperty
   a_wd_pulse: assert property (p_wd_pulse) else $error("watchdog reset longer than a cycle");
   property p_mode_rb;
      rb_v_q |-> bus_rdata_q == rb_q;
   endproperty
   a_mode_rb: assert property (p_mode_rb) else $error("mode or unmapped read wrong");
   property p_rd_idle;
      !$past(bus_rd) |-> bus_rdata_q == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
   property p_irq_quiet;
      (stab_q == 2'h3) && (eccf == 5'h00) |-> !irq_q;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt with enables clear");
   property p_pin_hold;
      (module_pin_oe_q == 5'h00) && ($past(module_pin_oe_q) == 5'h00) |-> $stable(module_pin_out);
   endproperty
   a_pin_hold: assert property (p_pin_hold) else $error("pin moved while undriven");
endmodule

bind cca_top cca_top_props chk_u (.clk, .rst_n, .ce, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
   .bus_rdata_q, .module_pin_in, .module_pin_out, .module_pin_oe_q, .irq_q, .wd_reset_q);

// [verification/test_counter_array_compare_capture.sv]
`define CHK(g, e) \
   begin \
      num_checks++; \
      if ((g) !== (e)) \
      begin \
         num_errors++; \
         $display("unexpected at %0t got %h exp %h", $time, (g), (e)); \
      end \
   end

// ====
// bench for the counter array
module test_counter_array_compare_capture;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        ce = 1'b1;
   logic [7:0]  bus_addr = 8'h00;
   logic [7:0]  bus_wdata = 8'h00;
   logic        bus_wr = 1'b0;
   logic        bus_rd = 1'b0;
   logic [4:0]  pin_level = 5'h00; // far-side pin levels
   wire  [7:0]  bus_rdata_q;
   wire  [4:0]  pin_wire;
   wire  [4:0]  pin_out;
   wire  [4:0]  pin_oe;
   wire         irq_q;
   wire         wd_reset_q;
   int          num_errors = 0;
   int          num_checks = 0;
   int          cycles = 0;
   int          wd_pulses = 0;
   logic [7:0]  cap_mode [3] = '{8'h21, 8'h10, 8'h30};
   logic [15:0] exp_cap;

   cca_top dut_u (.clk, .rst_n, .ce, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata_q,
      .module_pin_in(pin_wire), .module_pin_out(pin_out), .module_pin_oe_q(pin_oe), .irq_q, .wd_reset_q);
   cca_pin_model pm_u (.level(pin_level), .pin_out(pin_out), .pin_oe_q(pin_oe), .pin_wire(pin_wire));

   always #20 clk = ~clk;

   // watchdog pulse count and hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (wd_reset_q === 1'b1)
         wd_pulses++;
      if (cycles == 4000)
      begin
         num_errors++;
         finish_test();
      end
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_wr    <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      bus_addr <= a;
      bus_rd   <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1;
      `CHK(bus_rdata_q, e)
   endtask

   task automatic set_cnt(input logic [15:0] v);
      wr(8'h02, v[7:0]);
      wr(8'h03, v[15:8]);
      repeat (3) @(posedge clk);
   endtask

   // counter runs for exactly n increments, flags cleared on stop
   task automatic run_n(input int n);
      wr(8'h00, 8'h40);
      repeat (n - 2) @(posedge clk);
      wr(8'h00, 8'h00);
      repeat (3) @(posedge clk);
   endtask

   task finish_test;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if ((num_errors == 0) && (num_checks > 0))
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rchk(8'h10, 8'h00);
      rchk(8'hFF, 8'h00);
      wr(8'h10, 8'h7F);
      rchk(8'h10, 8'h7F);
      wr(8'h10, 8'h00);
      set_cnt(16'h00FE);
      run_n(3);
      rchk(8'h02, 8'h01);
      rchk(8'h03, 8'h01);
      // counter frozen while clock enable is low
      wr(8'h00, 8'h40);
      ce <= 1'b0;
      repeat (5) @(posedge clk);
      ce <= 1'b1;
      wr(8'h00, 8'h00);
      rchk(8'h02, 8'h03);
      $display("test registers done");
      // rise then fall on each capture polarity setting
      for (int i = 0; i < 3; i++)
      begin
         wr(8'h10 + 8'(i), cap_mode[i]);
         set_cnt(16'h1230 + 16'(i));
         pin_level[i] <= 1'b1;
         repeat (6) @(posedge clk);
         exp_cap = cap_mode[i][5] ? 16'h1230 + 16'(i) : 16'h0000;
         rchk(8'h20 + 8'(i), exp_cap[7:0]);
         rchk(8'h28 + 8'(i), exp_cap[15:8]);
         set_cnt(16'h4560 + 16'(i));
         pin_level[i] <= 1'b0;
         repeat (6) @(posedge clk);
         if (cap_mode[i][4])
            exp_cap = 16'h4560 + 16'(i);
         rchk(8'h20 + 8'(i), exp_cap[7:0]);
         rchk(8'h28 + 8'(i), exp_cap[15:8]);
         rchk(8'h00, 8'h01 << i);
         `CHK(irq_q, (i == 0) ? 1'b1 : 1'b0)
         wr(8'h00, 8'h00);
         rchk(8'h00, 8'h00);
         wr(8'h10 + 8'(i), 8'h00);
      end
      $display("test capture done");
      // timer on module 3, module 4 idle on the same compare value
      wr(8'h13, 8'h49);
      wr(8'h23, 8'h05);
      wr(8'h2B, 8'h01);
      wr(8'h24, 8'h05);
      wr(8'h2C, 8'h01);
      set_cnt(16'h0100);
      wr(8'h00, 8'h40);
      repeat (12) @(posedge clk);
      rchk(8'h00, 8'h48);
      `CHK(irq_q, 1'b1)
      wr(8'h00, 8'h00);
      wr(8'h13, 8'h00);
      $display("test timer done");
      // fast output toggles once per match
      wr(8'h11, 8'h4C);
      wr(8'h21, 8'h03);
      wr(8'h29, 8'h02);
      for (int k = 0; k < 2; k++)
      begin
         set_cnt(16'h0200);
         run_n(8);
         `CHK(pin_out[1], (k == 0) ? 1'b1 : 1'b0)
      end
      `CHK(pin_oe[1], 1'b1)
      wr(8'h11, 8'h00);
      $display("test fast output done");
      // two pwm outputs on the shared counter, reload at wrap
      wr(8'h12, 8'h42);
      wr(8'h22, 8'h80);
      wr(8'h2A, 8'h40);
      wr(8'h13, 8'h42);
      wr(8'h23, 8'h08);
      wr(8'h2B, 8'h08);
      set_cnt(16'h0010);
      `CHK(pin_out[3:2], 2'b10)
      set_cnt(16'h0080);
      `CHK(pin_out[2], 1'b1)
      set_cnt(16'h00FE);
      run_n(4);
      rchk(8'h22, 8'h40);
      set_cnt(16'h0040);
      `CHK(pin_out[2], 1'b1)
      `CHK(pin_oe[3:2], 2'b11)
      set_cnt(16'h0000);
      wr(8'h12, 8'h00);
      wr(8'h13, 8'h00);
      $display("test pwm done");
      // watchdog: disarmed, armed, armed with compare kept ahead
      wr(8'h14, 8'h48);
      wr(8'h2C, 8'h00);
      for (int k = 0; k < 3; k++)
      begin
         wr(8'h01, (k == 0) ? 8'h00 : 8'h40);
         wr(8'h24, (k == 2) ? 8'h40 : 8'h10);
         set_cnt(16'h0008);
         wd_pulses = 0;
         run_n(20);
         `CHK(wd_pulses, (k == 1) ? 1 : 0)
      end
      wr(8'h01, 8'h00);
      wr(8'h14, 8'h00);
      $display("test watchdog done");
      finish_test();
   end
endmodule
